//--- design/pin_mux_pkg.sv
// Shared constants, offsets and carrier types for the port pin function multiplexer.
package pin_mux_pkg;

   // ------------------------------------------------------------
   // Port geometry
   // ------------------------------------------------------------
   localparam int NPORT = 7;                 // Ports 4, 5, 6, 7, 8, 9 and A in that order.
   localparam int PW    = 8;                 // Pins per port; ports 7 and A use the low five.
   localparam int P4    = 0;                 // Index of port 4.
   localparam int P5    = 1;                 // Index of port 5.
   localparam int P6    = 2;                 // Index of port 6.
   localparam int P7    = 3;                 // Index of port 7.
   localparam int P8    = 4;                 // Index of port 8.
   localparam int P9    = 5;                 // Index of port 9.
   localparam int PA    = 6;                 // Index of port A.

   // ------------------------------------------------------------
   // Register offsets (byte addresses on the register port)
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_DATA_BASE  = 8'h04;  // Port data registers, one per port.
   localparam logic [7:0] OFS_DIR_BASE   = 8'h14;  // Port direction registers, one per port.
   localparam logic [7:0] OFS_OPEN_DRAIN = 8'h1B;  // port4_open_drain_reg.
   localparam logic [7:0] OFS_PULLUP     = 8'h1E;  // port6_pullup_reg.
   localparam logic [7:0] OFS_SER_CTRL   = 8'h30;  // serial_mode_ctrl_reg.
   localparam logic [7:0] OFS_DAC_CTRL   = 8'h31;  // dac_ctrl_reg.

   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int SOE1_BIT = 0;              // serial_out_enable for expansion serial 1.
   localparam int SOE2_BIT = 1;              // serial_out_enable for expansion serial 2.
   localparam int DAC0_BIT = 0;              // dac0_out_enable.
   localparam int DAC1_BIT = 1;              // dac1_out_enable.
   localparam logic [7:0] RST_BYTE = 8'h00;  // Reset value of every register.

   // ------------------------------------------------------------
   // Carrier types
   // ------------------------------------------------------------
   typedef logic [NPORT-1:0][PW-1:0] port_bus_type;   // One bit per pin of every port.

   // Signals that the on-chip peripherals present to the multiplexer.
   typedef struct packed {
      logic [1:0] ser_tx;        // Expansion serial data out, channels 1 and 2.
      logic [1:0] ser_clk;       // Expansion serial internal shift clock out.
      logic [1:0] ser_run;       // Expansion serial unit is operating.
      logic [1:0] ser_ext_clk;   // Expansion serial uses the external shift clock.
      logic [3:0] pg_out;        // Pulse generator outputs 00, 01, 10, 11.
      logic       pg_en;         // Pulse generator output enable.
      logic       clk_out;       // Clock output generator signal.
      logic       clk_out_run;   // Clock output generator operating.
      logic       adc_run;       // A/D converter operating.
      logic [3:0] cmp_event;     // Compare channel 0 to 3 event outputs.
   } periph_out_type;

   // Signals that the multiplexer returns to the on-chip peripherals.
   typedef struct packed {
      logic [1:0] ser_rx;        // exp_serial_rx1 and exp_serial_rx2.
      logic [1:0] ser_clk_in;    // External shift clocks exp_serial_clk1 and clk2.
      logic       adc_trig;      // adc_ext_trigger.
      logic [1:0] capture_trig;  // capture_trigger0 and capture_trigger1.
      logic [1:0] ud_phase_a;    // updown_phase_a0 and a1.
      logic [1:0] ud_phase_b;    // updown_phase_b0 and b1.
      logic [1:0] ud_zero;       // updown_zero0 and zero1.
      logic [7:0] ext_irq;       // ext_interrupt0 to ext_interrupt7.
      logic       analog_sel;    // Port 5 pins are switched to the A/D converter.
      logic [1:0] dac_connect;   // D/A outputs are switched onto their pins.
   } periph_in_type;

endpackage : pin_mux_pkg

//--- design/level_sync.sv
// Two-stage synchroniser for a bundle of asynchronous levels.
`timescale 1ns/1ps
module level_sync #(
   parameter int WIDTH = 8                 // Number of levels synchronised.
) (
   input  wire logic             sys_clk,  // System clock.
   input  wire logic             sys_rst,  // Asynchronous reset, active high.
   input  wire logic [WIDTH-1:0] async_in, // Levels from outside the clock domain.
   output logic      [WIDTH-1:0] sync_out  // Levels safe to use in the clock domain.
);

   logic [WIDTH-1:0] stage1;  // First stage, read only by the second stage.

   // The first stage feeds nothing but the second, so metastability settles there.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         stage1   <= '0;
         sync_out <= '0;
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end

endmodule : level_sync

//--- design/pin_cell.sv
// One shared port pin: selects port or peripheral drive and registers the pad controls.
`timescale 1ns/1ps
module pin_cell (
   input  wire logic sys_clk,   // System clock.
   input  wire logic sys_rst,   // Asynchronous reset, active high.
   input  wire logic dir,       // Direction bit, one means output.
   input  wire logic data,      // Port data register bit.
   input  wire logic od_sel,    // Open-drain selection bit.
   input  wire logic pu_sel,    // Pull-up selection bit.
   input  wire logic alt_en,    // Peripheral output function owns the pin.
   input  wire logic alt_val,   // Peripheral output value.
   input  wire logic force_in,  // Analog function: digital driver kept off.
   output logic      pad_out,   // Level driven onto the pad.
   output logic      pad_oe,    // Pad driver enable, high while driving.
   output logic      pull_up    // Internal pull-up connected.
);

   logic val;     // Value chosen for the pad.
   logic drive;   // Pad would be driven as a push-pull output.
   logic od_eff;  // Open-drain really in effect.

   // The peripheral value wins over the port data whenever its function is on.
   assign val    = alt_en ? alt_val : data;
   assign drive  = ~force_in & (alt_en | dir);
   // Open-drain only matters on an output; an input pin ignores the selection.
   assign od_eff = od_sel & dir;

   // Pad controls are registered so the pins never see a decode glitch.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pad_out <= 1'b0;
         pad_oe  <= 1'b0;
         pull_up <= 1'b0;
      end else begin
         // An open-drain pin only sinks: it releases the pad for a one.
         pad_out <= od_eff ? 1'b0 : val;
         pad_oe  <= drive & ~(od_eff & val);
         // The pull-up is meaningful only while nothing drives the pin.
         pull_up <= pu_sel & ~dir & ~alt_en & ~force_in;
      end
   end

endmodule : pin_cell

//--- design/port_pin_function_mux.sv
// Pin function multiplexer for ports 4 to A with its control registers.
`timescale 1ns/1ps
module port_pin_function_mux (
   input  wire logic                       sys_clk,   // System clock, 125 MHz.
   input  wire logic                       sys_rst,   // Asynchronous reset, active high.
   input  wire logic [7:0]                 reg_addr,  // Register byte address.
   input  wire logic [7:0]                 reg_wdata, // Register write data.
   input  wire logic                       reg_wr,    // Write strobe, one cycle.
   input  wire logic                       reg_rd,    // Read strobe, one cycle.
   output logic      [7:0]                 reg_rdata, // Read data, cycle after strobe.
   input  wire pin_mux_pkg::periph_out_type periph_o, // From the peripherals.
   output pin_mux_pkg::periph_in_type      periph_i,  // To the peripherals.
   input  wire pin_mux_pkg::port_bus_type  pin_in,    // Pad input levels.
   output pin_mux_pkg::port_bus_type       pin_out,   // Pad output levels.
   output pin_mux_pkg::port_bus_type       pin_oe,    // Pad output enables.
   output pin_mux_pkg::port_bus_type       pin_pu     // Pad pull-up enables.
);
   import pin_mux_pkg::*;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   port_bus_type data_reg;            // Port data registers.
   port_bus_type dir_reg;             // Port direction registers.
   logic [7:0]   port4_open_drain_reg; // Open-drain selection for port 4.
   logic [7:0]   port6_pullup_reg;    // Pull-up selection for port 6.
   logic [7:0]   serial_mode_ctrl_reg; // Serial output enables.
   logic [7:0]   dac_ctrl_reg;        // D/A output enables.

   // ------------------------------------------------------------
   // Internal signals
   // ------------------------------------------------------------
   port_bus_type pin_sync;            // Synchronised pad levels.
   port_bus_type alt_en;              // Peripheral output owns the pin.
   port_bus_type alt_val;             // Peripheral output value.
   port_bus_type force_in;            // Pin switched to an analog function.
   port_bus_type od_sel;              // Open-drain selection per pin.
   port_bus_type pu_sel;              // Pull-up selection per pin.
   logic [7:0]   next_rdata;          // Read data selected by the address.
   logic         hit_data;            // Address falls in the data registers.
   logic         hit_dir;             // Address falls in the direction registers.
   logic [7:0]   idx_data;            // Port index for a data access.
   logic [7:0]   idx_dir;             // Port index for a direction access.
   logic [1:0]   serial_out_enable;                 // Serial output enables, channels 1 and 2.
   logic [1:0]   dac_en;              // D/A output enables.

   assign serial_out_enable    = {serial_mode_ctrl_reg[SOE2_BIT], serial_mode_ctrl_reg[SOE1_BIT]};
   assign dac_en = {dac_ctrl_reg[DAC1_BIT], dac_ctrl_reg[DAC0_BIT]};

   // ------------------------------------------------------------
   // Pad input synchroniser
   // ------------------------------------------------------------
   // Every pad level crosses two flops before any decode looks at it.
   level_sync #(
      .WIDTH    (NPORT*PW)
   ) u_pin_sync (
      .sys_clk  (sys_clk),
      .sys_rst  (sys_rst),
      .async_in (pin_in),
      .sync_out (pin_sync)
   );

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   // Data and direction registers sit in two runs of consecutive bytes.
   assign idx_data = reg_addr - OFS_DATA_BASE;
   assign idx_dir  = reg_addr - OFS_DIR_BASE;
   assign hit_data = (reg_addr >= OFS_DATA_BASE) && (idx_data < 8'(NPORT));
   assign hit_dir  = (reg_addr >= OFS_DIR_BASE) && (idx_dir < 8'(NPORT));

   // Port and direction registers are written by software only.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         data_reg <= '0;
         dir_reg  <= '0;
      end else if (reg_wr) begin
         if (hit_data) begin
            data_reg[idx_data[2:0]] <= reg_wdata;
         end
         if (hit_dir) begin
            dir_reg[idx_dir[2:0]] <= reg_wdata;
         end
      end
   end

   // Pin configuration registers.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         port4_open_drain_reg <= RST_BYTE;
         port6_pullup_reg     <= RST_BYTE;
         serial_mode_ctrl_reg <= RST_BYTE;
         dac_ctrl_reg         <= RST_BYTE;
      end else if (reg_wr) begin
         case (reg_addr)
            OFS_OPEN_DRAIN: port4_open_drain_reg <= reg_wdata;
            OFS_PULLUP:     port6_pullup_reg     <= reg_wdata;
            OFS_SER_CTRL:   serial_mode_ctrl_reg <= reg_wdata;
            OFS_DAC_CTRL:   dac_ctrl_reg         <= reg_wdata;
            default: begin
            end
         endcase
      end
   end

   // Read mux.  A data read returns the pad level for input pins and the
   // register for output pins, so software sees what the pin really does.
   always_comb begin
      next_rdata = 8'h00;
      if (hit_data) begin
         next_rdata = (dir_reg[idx_data[2:0]] & data_reg[idx_data[2:0]])
                    | (~dir_reg[idx_data[2:0]] & pin_sync[idx_data[2:0]]);
      end else if (hit_dir) begin
         next_rdata = dir_reg[idx_dir[2:0]];
      end else begin
         case (reg_addr)
            OFS_OPEN_DRAIN: next_rdata = port4_open_drain_reg;
            OFS_PULLUP:     next_rdata = port6_pullup_reg;
            OFS_SER_CTRL:   next_rdata = serial_mode_ctrl_reg;
            OFS_DAC_CTRL:   next_rdata = dac_ctrl_reg;
            default:        next_rdata = 8'h00;
         endcase
      end
   end

   // Read data stand for exactly one cycle; unmapped addresses read zero.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_rd ? next_rdata : 8'h00;
      end
   end

   // ------------------------------------------------------------
   // Pin function selection
   // ------------------------------------------------------------
   // Open-drain exists only on port 4 and pull-ups only on port 6.
   always_comb begin
      od_sel     = '0;
      pu_sel     = '0;
      od_sel[P4] = port4_open_drain_reg;
      pu_sel[P6] = port6_pullup_reg;
   end

   // Which peripheral owns which pin; anything not listed stays a port pin.
   always_comb begin
      alt_en   = '0;
      alt_val  = '0;
      force_in = '0;
      // Expansion serial 1 data and internal clock out on port 4.
      alt_en[P4][4]  = serial_out_enable[0];
      alt_val[P4][4] = periph_o.ser_tx[0];
      // In external shift clock mode the clock pin is an input only.
      alt_en[P4][5]  = serial_out_enable[0] & ~periph_o.ser_ext_clk[0];
      alt_val[P4][5] = periph_o.ser_clk[0];
      // Expansion serial 2 on port 6.
      alt_en[P6][1]  = serial_out_enable[1];
      alt_val[P6][1] = periph_o.ser_tx[1];
      alt_en[P6][2]  = serial_out_enable[1] & ~periph_o.ser_ext_clk[1];
      alt_val[P6][2] = periph_o.ser_clk[1];
      // Pulse generator on port 6 pins 3, 4, 6 and 7.
      alt_en[P6][3]  = periph_o.pg_en;
      alt_val[P6][3] = periph_o.pg_out[0];
      alt_en[P6][4]  = periph_o.pg_en;
      alt_val[P6][4] = periph_o.pg_out[1];
      alt_en[P6][6]  = periph_o.pg_en;
      alt_val[P6][6] = periph_o.pg_out[2];
      alt_en[P6][7]  = periph_o.pg_en;
      alt_val[P6][7] = periph_o.pg_out[3];
      // Clock output on port 6 pin 5.
      alt_en[P6][5]  = periph_o.clk_out_run;
      alt_val[P6][5] = periph_o.clk_out;
      // Compare events own port A pins 0 to 3 at all times.
      alt_en[PA][3:0]  = 4'hF;
      alt_val[PA][3:0] = periph_o.cmp_event;
      // Analog functions keep the digital driver off.
      force_in[P5]    = {PW{periph_o.adc_run}};
      force_in[P7][3] = dac_en[0];
      force_in[P7][4] = dac_en[1];
   end

   // ------------------------------------------------------------
   // Pin cells
   // ------------------------------------------------------------
   // One cell per pin keeps the drive decision identical on every port.
   for (genvar p = 0; p < NPORT; p++) begin : g_port
      for (genvar b = 0; b < PW; b++) begin : g_bit
         pin_cell u_cell (
            .sys_clk  (sys_clk),
            .sys_rst  (sys_rst),
            .dir      (dir_reg[p][b]),
            .data     (data_reg[p][b]),
            .od_sel   (od_sel[p][b]),
            .pu_sel   (pu_sel[p][b]),
            .alt_en   (alt_en[p][b]),
            .alt_val  (alt_val[p][b]),
            .force_in (force_in[p][b]),
            .pad_out  (pin_out[p][b]),
            .pad_oe   (pin_oe[p][b]),
            .pull_up  (pin_pu[p][b])
         );
      end
   end

   // ------------------------------------------------------------
   // Peripheral inputs
   // ------------------------------------------------------------
   // Inputs are taken from the synchronised pads and registered once more.
   // An idle serial line reads high so a stopped unit never sees a start bit.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         periph_i <= '0;
      end else begin
         periph_i.ser_rx[0] <= periph_o.ser_run[0] ? pin_sync[P4][3] : 1'b1;
         periph_i.ser_rx[1] <= periph_o.ser_run[1] ? pin_sync[P6][0] : 1'b1;
         periph_i.ser_clk_in[0] <= periph_o.ser_ext_clk[0] ? pin_sync[P4][5] : 1'b1;
         periph_i.ser_clk_in[1] <= periph_o.ser_ext_clk[1] ? pin_sync[P6][2] : 1'b1;
         periph_i.adc_trig     <= pin_sync[P4][6];
         periph_i.capture_trig <= pin_sync[P9][7:6];
         periph_i.ud_phase_a   <= {pin_sync[P9][3], pin_sync[P9][0]};
         periph_i.ud_phase_b   <= {pin_sync[P9][4], pin_sync[P9][1]};
         periph_i.ud_zero      <= {pin_sync[P9][5], pin_sync[P9][2]};
         periph_i.ext_irq      <= {pin_sync[P9][3], pin_sync[P9][0], pin_sync[P8][5:0]};
         periph_i.analog_sel   <= periph_o.adc_run;
         periph_i.dac_connect  <= dac_en;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   // Pad high held for four samples reaches the peripheral input.
   sequence s_clk_pin_high;
      (periph_o.ser_ext_clk[0] && pin_in[P4][5])[*4];
   endsequence

   sequence s_rx_pin_low;
      (periph_o.ser_run[0] && !pin_in[P4][3])[*4];
   endsequence

   chk_od_release: assert property (
      (dir_reg[P4][7] && port4_open_drain_reg[7] && data_reg[P4][7]) |=> !pin_oe[P4][7])
      else $error("open-drain pin drove a high level");

   chk_od_sink: assert property (
      (dir_reg[P4][7] && port4_open_drain_reg[7] && !data_reg[P4][7])
      |=> (pin_oe[P4][7] && !pin_out[P4][7]))
      else $error("open-drain pin failed to sink a low level");

   chk_od_input: assert property (
      (!dir_reg[P4][6] && port4_open_drain_reg[6]) |=> !pin_oe[P4][6])
      else $error("input pin with open-drain selection is driven");

   chk_pullup_on: assert property (
      (!dir_reg[P6][0] && port6_pullup_reg[0]) |=> pin_pu[P6][0])
      else $error("pull-up not connected on input pin");

   chk_pullup_ignored: assert property (
      dir_reg[P6][0] |=> !pin_pu[P6][0])
      else $error("pull-up connected on output pin");

   chk_soe_tx_drive: assert property (
      (serial_out_enable[0] && !(dir_reg[P4][4] && port4_open_drain_reg[4]))
      |=> (pin_oe[P4][4] && pin_out[P4][4] == $past(periph_o.ser_tx[0])))
      else $error("serial data pin not driven by the serial unit");

   chk_ext_clk_in: assert property (
      s_clk_pin_high |-> periph_i.ser_clk_in[0])
      else $error("external shift clock not taken from the pin");

   chk_rx_sample: assert property (
      s_rx_pin_low |-> !periph_i.ser_rx[0])
      else $error("serial input pin not sampled while running");

   chk_dac_hiz: assert property (
      dac_en[0] |=> (!pin_oe[P7][3] && periph_i.dac_connect[0]))
      else $error("D/A pin driven digitally while analog");

   chk_pg_priority: assert property (
      periph_o.pg_en |=> (pin_oe[P6][3] && pin_out[P6][3] == $past(periph_o.pg_out[0])))
      else $error("pulse generator output not on its pin");

   chk_clk_out_off: assert property (
      (!periph_o.clk_out_run && !dir_reg[P6][5]) |=> !pin_oe[P6][5])
      else $error("clock output pin driven while generator is stopped");

   chk_adc_analog: assert property (
      periph_o.adc_run |=> (pin_oe[P5] == '0 && periph_i.analog_sel))
      else $error("analog input pin driven during conversion");

   chk_cmp_route: assert property (
      1'b1 |=> (pin_oe[PA][0] && pin_out[PA][0] == $past(periph_o.cmp_event[0])))
      else $error("compare event not routed to port A");

   // An enabled peripheral output must win even when the port bit is an output.
   chk_alt_wins: assert property (
      (periph_o.clk_out_run && dir_reg[P6][5])
      |=> (pin_out[P6][5] == $past(periph_o.clk_out)))
      else $error("port data beat an enabled peripheral output");

   // With the serial output off, an input-direction data pin stays released.
   chk_soe_off: assert property (
      (!serial_out_enable[0] && !dir_reg[P4][4]) |=> !pin_oe[P4][4])
      else $error("serial data pin driven with serial output disabled");

   // While the unit takes an external clock, an input-direction clock pin stays released.
   chk_ext_clk_hiz: assert property (
      (periph_o.ser_ext_clk[0] && !dir_reg[P4][5]) |=> !pin_oe[P4][5])
      else $error("clock pin driven in external shift clock mode");

   // A stopped unit must see an idle high line, never a false start bit.
   chk_rx_idle: assert property (
      !periph_o.ser_run[0] |=> periph_i.ser_rx[0])
      else $error("stopped serial unit sees a low input");

   chk_dac1_hiz: assert property (
      dac_en[1] |=> (!pin_oe[P7][4] && periph_i.dac_connect[1]))
      else $error("second D/A pin driven digitally while analog");

   // With the pulse outputs disabled an input pin falls back to a plain port.
   chk_pg_off: assert property (
      (!periph_o.pg_en && !dir_reg[P6][7]) |=> !pin_oe[P6][7])
      else $error("pulse pin driven while pulse output is disabled");

   // Trigger pad high held for four samples reaches capture channel 0.
   sequence s_capture_high;
      (pin_in[P9][6])[*4];
   endsequence

   chk_capture_route: assert property (
      s_capture_high |-> periph_i.capture_trig[0])
      else $error("capture trigger not taken from port 9");

endmodule : port_pin_function_mux

//--- testbench/board_model.sv
// Board-side model that settles the level seen on every shared port pad.
`timescale 1ns/1ps
module board_model (
   input  wire logic                      sys_clk, // System clock.
   input  wire pin_mux_pkg::port_bus_type pin_out, // Pad levels from the device.
   input  wire pin_mux_pkg::port_bus_type pin_oe,  // Pad drive enables.
   input  wire pin_mux_pkg::port_bus_type pin_pu,  // Internal pull-ups in place.
   input  wire pin_mux_pkg::port_bus_type ext_en,  // Board drivers enabled.
   input  wire pin_mux_pkg::port_bus_type ext_val, // Board driver levels.
   output pin_mux_pkg::port_bus_type      pin_in   // Settled pad levels.
);
   import pin_mux_pkg::*;
   logic flip = 1'b0; // A floating pad wanders, so a missed drive cannot pass by luck.
   // Toggle the floating level on every clock.
   always @(posedge sys_clk) begin
      flip <= ~flip;
   end
   // The device wins, then the board, then the pull-up, else the wandering level.
   assign pin_in = pin_oe & pin_out
                 | ~pin_oe & (ext_en & ext_val | ~ext_en & (pin_pu | {NPORT*PW{flip}}));
endmodule : board_model

//--- testbench/port_pin_function_mux_tb.sv
// Self-checking bench for the port pin function multiplexer.
`timescale 1ns/1ps
module port_pin_function_mux_tb;
   import pin_mux_pkg::*;
   logic sys_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   periph_out_type po = '0;
   periph_in_type pi;
   port_bus_type pin_in, pin_out, pin_oe, pin_pu, ext_val = '0, ext_en = '0;
   int err_total = 0, checks_done = 0;
   logic [7:0] r [10]; // Image: dir4 dir5 dir6 dir7 data4 data6 od pu ser dac.
   logic [7:0] adr [10] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h04, 8'h06, 8'h1B, 8'h1E,
                           8'h30, 8'h31};
   always #4 sys_clk = ~sys_clk;
   port_pin_function_mux dut (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .periph_o(po), .periph_i(pi), .pin_in, .pin_out, .pin_oe, .pin_pu);
   board_model board (.sys_clk, .pin_out, .pin_oe, .pin_pu, .ext_en, .ext_val, .pin_in);
   // ----------------------------------------
   // Bus cycles and comparison
   // ----------------------------------------
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp8
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      // Let one edge pass so a following write never reassigns the strobe at once.
      @(posedge sys_clk);
   endtask : wr
   // Read data stand only in the cycle after the strobe, so look there.
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 cmp8(reg_rdata, e);
      @(posedge sys_clk);
   endtask : rd_chk
   // Work out the port 4, 5, 6, 7 and A pads and the capture, serial 1, analog and D/A returned levels from the register image.
   task automatic check_pads();
      logic [7:0] a4, v4, od, e4, a6, v6, e6;
      a4 = {2'b00, r[8][0] & ~po.ser_ext_clk[0], r[8][0], 4'h0};
      v4 = a4 & {2'b00, po.ser_clk[0], po.ser_tx[0], 4'h0} | ~a4 & r[4];
      od = r[6] & r[0];
      e4 = od & ~v4 | ~od & (a4 | r[0]);
      a6 = {{2{po.pg_en}}, po.clk_out_run, {2{po.pg_en}}, r[8][1] & ~po.ser_ext_clk[1],
            r[8][1], 1'b0};
      v6 = a6 & {po.pg_out[3:2], po.clk_out, po.pg_out[1:0], po.ser_clk[1], po.ser_tx[1],
            1'b0} | ~a6 & r[5];
      e6 = a6 | r[2];
      cmp8(pin_oe[P4], e4);
      cmp8(pin_out[P4] & e4, ~od & v4 & e4);
      cmp8(pin_oe[P6], e6);
      cmp8(pin_out[P6] & e6, v6 & e6);
      cmp8(pin_pu[P6], r[7] & ~r[2] & ~a6);
      cmp8(pin_oe[P5], po.adc_run ? 8'h00 : r[1]);
      cmp8(pin_oe[P7], r[3] & ~{3'b000, r[9][1:0], 3'b000});
      cmp8({pin_oe[PA][3:0], pin_out[PA][3:0]}, {4'hF, po.cmp_event});
      cmp8({4'h0, pi.capture_trig, pi.ser_rx[0], pi.ser_clk_in[0]}, {4'h0,
         ext_val[P9][7:6], po.ser_run[0] ? ext_val[P4][3] : 1'b1,
         po.ser_ext_clk[0] ? ext_val[P4][5] : 1'b1});
      cmp8({5'h00, pi.analog_sel, pi.dac_connect}, {5'h00, po.adc_run, r[9][1:0]});
   endtask : check_pads
   task automatic print_verdict();
      $display("mismatches %0d, comparisons %0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : print_verdict
   // Cut a hang short well past the expected run length.
   initial begin
      #30us;
      err_total++;
      print_verdict();
   end
   // Reset values, an unmapped place, then random settings with all-ones and all-zeros first.
   initial begin
      void'($urandom(33));
      ext_en[P9] = 8'hFF;
      // Ports 4 and 6 are held by the board so their data reads never float.
      ext_en[P4] = 8'hFF;
      ext_en[P6] = 8'hFF;
      repeat (10) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      for (int k = 0; k < 10; k++) rd_chk(adr[k], 8'h00);
      wr(8'h0B, 8'hFF);
      rd_chk(8'h0B, 8'h00);
      for (int i = 0; i < 12; i++) begin
         for (int k = 0; k < 10; k++) begin
            r[k] = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
            if (k == 0) r[k] &= 8'hD7; // Keep the serial input pads free for the board.
            wr(adr[k], r[k]);
         end
         po <= (i == 0) ? '1 : (i == 1) ? '0 : 20'($urandom);
         ext_val[P4] <= 8'($urandom);
         ext_val[P9] <= 8'($urandom);
         repeat (5) @(posedge sys_clk);
         #1 check_pads();
         @(posedge sys_clk);
         for (int k = 0; k < 10; k++) if (k < 4 || k > 5) rd_chk(adr[k], r[k]);
      end
      print_verdict();
   end
endmodule : port_pin_function_mux_tb
